// File: jsba_cfg.svh
/*
 * Constants for the debug-port service bus access block: instruction codes,
 * scan lengths, field positions, register offsets and reset values.
 * Assumes inclusion by bare name from the block's package and module.
 */
`ifndef JSBA_CFG_SVH
`define JSBA_CFG_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define JSBA_IR_WIDTH        5
`define JSBA_IR_MSU          5'h14
`define JSBA_IR_SIZED        5'h15
`define JSBA_IR_WORD         5'h11
`define JSBA_IR_BYPASS       5'h1F
`define JSBA_IR_CAP_LOW      2'h1

// ----------------------------------------------------------------------
// Scan lengths
// ----------------------------------------------------------------------
`define JSBA_DR_MAX          39
`define JSBA_LEN_MSU         6'h22
`define JSBA_LEN_SIZED       6'h27
`define JSBA_LEN_WORD        6'h23
`define JSBA_LEN_BYPASS      6'h01

// ----------------------------------------------------------------------
// Address phase fields
// ----------------------------------------------------------------------
`define JSBA_DIR_POS         0
`define JSBA_MSU_IDX_LO      1
`define JSBA_MSU_IDX_HI      7
`define JSBA_SIZE_LO         1
`define JSBA_SIZE_HI         2
`define JSBA_SADDR_LO        3
`define JSBA_SADDR_HI        38
`define JSBA_WADDR_LO        1
`define JSBA_WADDR_HI        34
`define JSBA_DIR_READ        1'b1

// ----------------------------------------------------------------------
// Size codes
// ----------------------------------------------------------------------
`define JSBA_SIZE_BYTE       2'h0
`define JSBA_SIZE_HALF       2'h1
`define JSBA_SIZE_WORD       2'h2

// ----------------------------------------------------------------------
// APB registers
// ----------------------------------------------------------------------
`define JSBA_OFS_CTRL        12'h000
`define JSBA_OFS_STATUS      12'h004
`define JSBA_CTRL_EN_POS     0
`define JSBA_CTRL_RESET      1'b1

`endif

// File: jsba_pkg.sv
/*
 * Types for the debug-port service bus access block.
 * Assumes jsba_cfg.svh is on the include path.
 */
`include "jsba_cfg.svh"

package jsba_pkg;

  typedef enum logic [3:0] {
    JSBA_RESET    = 4'h8,
    JSBA_IDLE     = 4'h0,
    JSBA_SEL_DR   = 4'h1,
    JSBA_CAP_DR   = 4'h3,
    JSBA_SHIFT_DR = 4'h2,
    JSBA_EXIT1_DR = 4'h6,
    JSBA_PAUSE_DR = 4'h7,
    JSBA_EXIT2_DR = 4'h5,
    JSBA_UPD_DR   = 4'h4,
    JSBA_SEL_IR   = 4'hC,
    JSBA_CAP_IR   = 4'hD,
    JSBA_SHIFT_IR = 4'hF,
    JSBA_EXIT1_IR = 4'hE,
    JSBA_PAUSE_IR = 4'hA,
    JSBA_EXIT2_IR = 4'hB,
    JSBA_UPD_IR   = 4'h9
  } jsba_tap_t;

  // Service bus request, held until acknowledged
  typedef struct packed {
    logic        req;
    logic        msu;
    logic        write;
    logic [35:0] addr;
    logic [1:0]  size;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } jsba_bus_t;

  typedef struct packed {
    logic [2:0]                   sync1;
    logic [2:0]                   sync2;
    logic                         tck_d;
    jsba_tap_t                    tap;
    logic [`JSBA_IR_WIDTH-1:0]    ir;
    logic [`JSBA_IR_WIDTH-1:0]    ir_sr;
    logic [`JSBA_DR_MAX-1:0]      dr_sr;
    logic                         data_ph;
    logic                         busy;
    logic                         err;
    logic [31:0]                  rdata;
    jsba_bus_t                    bus;
    logic                         tdo;
    logic                         tdo_oe;
    logic                         enable;
    logic [31:0]                  prdata;
    logic                         pslverr;
  } jsba_state_t;

endpackage

// File: jsba_target.sv
/*
 * Service bus target model: sixteen words, prompt or slow acks.
 * Assumes one outstanding request; bit 8 of the address marks a word-only unit.
 */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Target
// ----------------------------------------------------------------------
module jsba_target (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        slow_i,
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic [35:0] addr_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  output logic             ack_o,
  output logic             err_o,
  output logic [31:0]      rdata_o,
  output int               xfers_o
);
  logic [31:0] mem [16];
  int          wait_n;
  always_ff @(posedge clock_i) begin
    ack_o <= 1'b0;
    if (srst_i) begin
      wait_n <= 0;
      xfers_o <= 0;
      err_o <= 1'b0;
      rdata_o <= 32'hA5A5A5A5;
    end else if (req_i && !ack_o) begin
      // Slow mode outlasts a short data scan so busy is seen
      if (wait_n >= (slow_i ? 400 : 2)) begin
        wait_n <= 0;
        ack_o <= 1'b1;
        xfers_o <= xfers_o + 1;
        err_o <= addr_i[8] && size_i != 2'h2;
        rdata_o <= mem[addr_i[5:2]];
        for (int b = 0; b < 4; b++) begin
          if (write_i && be_i[b]) begin
            mem[addr_i[5:2]][8*b+:8] <= wdata_i[8*b+:8];
          end
        end
      end else begin
        wait_n <= wait_n + 1;
      end
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// File: jsba_top.sv
/*
 * Debug-port access to the service access bus: a test access port state
 * machine sampled by the system clock, three private scan paths and a
 * service bus master, plus a small APB register block.
 * Assumes jtag pins come from outside the clock domain; service bus and APB
 * run on clock_i.
 */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "jsba_cfg.svh"

// What this block does
// - Code 10100 reaches memory-unit registers by 7-bit index, direction and 32 data bits.
// - Start in address phase; toggle phase only when a scan ends with busy clear.
// - Direction bit 1 means read, 0 means write.
// - Memory-unit scan is 34 bits; direction at bit 0, index just above.
// - Memory-unit read data phase returns 32 data bits with error and busy above.
// - Read data scans may stop early without harm.
// - Code 10101 uses 39-bit scan: 36-bit byte address, size, direction, data.
// - Size 00 byte, 01 halfword, 10 word, 11 reserved.
// - Byte lane follows address mod 4; remainder 0 is the top byte.
// - Halfwords only at remainder 0 (upper) or 2 (lower).
// - Words only at addresses that are multiples of four.
// - Sized address phase: direction bit 0, size above, 36-bit address above.
// - Sized read data phase: 32 data bits, status above, zero fill beyond.
// - Targets may refuse some sizes; their refusal shows as the error bit.
// - Code 10001 does word accesses over 35 bits; low two address bits zero.
// - Word-only status sits in bits 1:0 at address phase, above data on read.
module jsba_top
  import jsba_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  output logic             bus_req_o,
  output logic             bus_msu_o,
  output logic             bus_write_o,
  output logic [35:0]      bus_addr_o,
  output logic [1:0]       bus_size_o,
  output logic [3:0]       bus_byte_en_o,
  output logic [31:0]      bus_wdata_o,
  input  wire logic        bus_ack_i,
  input  wire logic        bus_err_i,
  input  wire logic [31:0] bus_rdata_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  jsba_state_t st;
  jsba_state_t next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Chain length per instruction; anything unknown falls back to bypass
  function automatic logic [5:0] dr_len(input logic [`JSBA_IR_WIDTH-1:0] ir);
    logic [5:0] len;
    len = `JSBA_LEN_BYPASS;
    unique case (ir)
      `JSBA_IR_MSU:   len = `JSBA_LEN_MSU;
      `JSBA_IR_SIZED: len = `JSBA_LEN_SIZED;
      `JSBA_IR_WORD:  len = `JSBA_LEN_WORD;
      default:        len = `JSBA_LEN_BYPASS;
    endcase
    return len;
  endfunction

  // Test access port moves, applied once per detected tck rise
  function automatic jsba_tap_t tap_next(input jsba_tap_t s, input logic tms);
    jsba_tap_t n;
    n = s;
    unique case (s)
      JSBA_RESET:    n = tms ? JSBA_RESET    : JSBA_IDLE;
      JSBA_IDLE:     n = tms ? JSBA_SEL_DR   : JSBA_IDLE;
      JSBA_SEL_DR:   n = tms ? JSBA_SEL_IR   : JSBA_CAP_DR;
      JSBA_CAP_DR:   n = tms ? JSBA_EXIT1_DR : JSBA_SHIFT_DR;
      JSBA_SHIFT_DR: n = tms ? JSBA_EXIT1_DR : JSBA_SHIFT_DR;
      JSBA_EXIT1_DR: n = tms ? JSBA_UPD_DR   : JSBA_PAUSE_DR;
      JSBA_PAUSE_DR: n = tms ? JSBA_EXIT2_DR : JSBA_PAUSE_DR;
      JSBA_EXIT2_DR: n = tms ? JSBA_UPD_DR   : JSBA_SHIFT_DR;
      JSBA_UPD_DR:   n = tms ? JSBA_SEL_DR   : JSBA_IDLE;
      JSBA_SEL_IR:   n = tms ? JSBA_RESET    : JSBA_CAP_IR;
      JSBA_CAP_IR:   n = tms ? JSBA_EXIT1_IR : JSBA_SHIFT_IR;
      JSBA_SHIFT_IR: n = tms ? JSBA_EXIT1_IR : JSBA_SHIFT_IR;
      JSBA_EXIT1_IR: n = tms ? JSBA_UPD_IR   : JSBA_PAUSE_IR;
      JSBA_PAUSE_IR: n = tms ? JSBA_EXIT2_IR : JSBA_PAUSE_IR;
      JSBA_EXIT2_IR: n = tms ? JSBA_UPD_IR   : JSBA_SHIFT_IR;
      JSBA_UPD_IR:   n = tms ? JSBA_SEL_DR   : JSBA_IDLE;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------------
  // Decoded pins and per-scan helpers
  // ----------------------------------------------------------------------
  logic                     tck_rise;
  logic                     tck_fall;
  logic                     tms_s;
  logic                     tdi_s;
  logic                     sel_msu;
  logic                     sel_sized;
  logic                     sel_word;
  logic                     sel_any;
  logic [5:0]               len;
  logic [`JSBA_DR_MAX-1:0]  shifted;
  logic [`JSBA_DR_MAX-1:0]  capture;
  logic [35:0]              a_addr;
  logic [1:0]               a_size;
  logic                     a_read;
  logic [3:0]               a_be;
  logic                     a_bad;
  logic                     apb_setup;

  // Only the second synchroniser stage is ever looked at
  assign tck_rise  = st.sync2[2] & ~st.tck_d;
  assign tck_fall  = ~st.sync2[2] & st.tck_d;
  assign tms_s     = st.sync2[1];
  assign tdi_s     = st.sync2[0];
  assign sel_msu   = (st.ir == `JSBA_IR_MSU);
  assign sel_sized = (st.ir == `JSBA_IR_SIZED);
  assign sel_word  = (st.ir == `JSBA_IR_WORD);
  assign sel_any   = sel_msu | sel_sized | sel_word;
  assign len       = dr_len(st.ir);
  assign apb_setup = psel_i & ~penable_i;

  // ----------------------------------------------------------------------
  // Scan path shaping
  // ----------------------------------------------------------------------
  // New bit enters at the top of the active length; LSB leaves first
  genvar gi;
  generate
    for (gi = 0; gi < `JSBA_DR_MAX; gi++) begin : g_shift
      if (gi == `JSBA_DR_MAX - 1) begin : g_top
        assign shifted[gi] = (len == 6'(gi + 1)) ? tdi_s : 1'b0;
      end else begin : g_mid
        assign shifted[gi] = (len == 6'(gi + 1)) ? tdi_s :
                             (6'(gi + 1) < len)  ? st.dr_sr[gi + 1] : 1'b0;
      end
    end
  endgenerate

  // Address phases capture zeros, except the word path's status pair
  always_comb begin
    capture = '0;
    if (sel_any && st.data_ph) begin
      capture[33:0] = {st.err, st.busy, st.rdata};
    end else if (sel_word) begin
      capture[1:0] = {st.err, st.busy};
    end
  end

  // ----------------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------------
  always_comb begin
    a_read = (st.dr_sr[`JSBA_DIR_POS] == `JSBA_DIR_READ);
    a_addr = '0;
    a_size = `JSBA_SIZE_WORD;
    a_be   = 4'hF;
    a_bad  = 1'b0;
    if (sel_msu) begin
      a_addr[6:0] = st.dr_sr[`JSBA_MSU_IDX_HI:`JSBA_MSU_IDX_LO];
    end else if (sel_sized) begin
      a_addr = st.dr_sr[`JSBA_SADDR_HI:`JSBA_SADDR_LO];
      a_size = st.dr_sr[`JSBA_SIZE_HI:`JSBA_SIZE_LO];
    end else begin
      a_addr = {st.dr_sr[`JSBA_WADDR_HI:`JSBA_WADDR_LO], 2'h0};
    end
    unique case (a_size)
      `JSBA_SIZE_BYTE: a_be = 4'h8 >> a_addr[1:0];
      `JSBA_SIZE_HALF: begin
        a_be  = a_addr[1] ? 4'h3 : 4'hC;
        a_bad = a_addr[0];
      end
      // A register index has no alignment; only byte addresses are checked
      `JSBA_SIZE_WORD: a_bad = !sel_msu && (a_addr[1:0] != 2'h0);
      default:         a_bad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st       = st;

    // ----------------------------------------------------------------------
    // Pin synchronisers and tck edge history
    // ----------------------------------------------------------------------
    next_st.sync1 = {tck_i, tms_i, tdi_i};
    next_st.sync2 = st.sync1;
    next_st.tck_d = st.sync2[2];

    // ----------------------------------------------------------------------
    // Service bus completion
    // ----------------------------------------------------------------------
    // A target refusing the size reports an error
    if (st.bus.req && bus_ack_i) begin
      next_st.bus.req = 1'b0;
      next_st.busy    = 1'b0;
      next_st.err     = st.err | bus_err_i;
      if (!st.bus.write) begin
        next_st.rdata = bus_rdata_i;
      end
    end

    // ----------------------------------------------------------------------
    // Test access port
    // ----------------------------------------------------------------------
    // Scan moves and register updates happen only on a detected rise
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, tms_s);
      unique case (st.tap)
        JSBA_RESET: begin
          next_st.ir      = `JSBA_IR_BYPASS;
          next_st.data_ph = 1'b0;
        end
        JSBA_CAP_IR: begin
          next_st.ir_sr = {1'b0, st.err, st.busy, `JSBA_IR_CAP_LOW};
        end
        JSBA_SHIFT_IR: begin
          next_st.ir_sr = {tdi_s, st.ir_sr[`JSBA_IR_WIDTH-1:1]};
        end
        JSBA_UPD_IR: begin
          // A newly selected access always starts with an address scan
          next_st.ir      = st.ir_sr;
          next_st.data_ph = 1'b0;
        end
        JSBA_CAP_DR: begin
          next_st.dr_sr = capture;
        end
        JSBA_SHIFT_DR: begin
          next_st.dr_sr = shifted;
        end
        JSBA_UPD_DR: begin
          // A busy scan is a status poll: no phase change, no new transfer
          if (sel_any && !st.busy) begin
            next_st.data_ph = ~st.data_ph;
            if (!st.data_ph) begin
              next_st.err         = 1'b0;
              next_st.bus.msu     = sel_msu;
              next_st.bus.write   = ~a_read;
              next_st.bus.addr    = a_addr;
              next_st.bus.size    = a_size;
              next_st.bus.byte_en = a_be;
              // Refused phases still toggle, keeping the debugger in step
              if (a_bad || !st.enable) begin
                next_st.err       = 1'b1;
                next_st.bus.write = 1'b0;
              end else if (a_read) begin
                next_st.bus.req = 1'b1;
                next_st.busy    = 1'b1;
              end
            end else if (st.bus.write) begin
              next_st.bus.wdata = st.dr_sr[31:0];
              next_st.bus.req   = 1'b1;
              next_st.busy      = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------------
    // Test data out
    // ----------------------------------------------------------------------
    // Output changes on the falling edge so the debugger samples it stable
    if (tck_fall) begin
      next_st.tdo_oe = (st.tap == JSBA_SHIFT_DR) || (st.tap == JSBA_SHIFT_IR);
      next_st.tdo    = (st.tap == JSBA_SHIFT_IR) ? st.ir_sr[0] : st.dr_sr[0];
    end

    // ----------------------------------------------------------------------
    // APB register access
    // ----------------------------------------------------------------------
    // Answer prepared in the setup cycle, zero wait states
    if (apb_setup) begin
      next_st.pslverr = 1'b0;
      next_st.prdata  = '0;
      unique case (paddr_i)
        `JSBA_OFS_CTRL:   next_st.prdata[`JSBA_CTRL_EN_POS] = st.enable;
        `JSBA_OFS_STATUS: next_st.prdata[8:0] = {st.ir, st.data_ph, st.err, st.busy,
                                                 st.bus.req};
        default:          next_st.pslverr = 1'b1;
      endcase
    end
    // Status is read only; a write to it is dropped without an error
    if (psel_i && penable_i && pwrite_i && paddr_i == `JSBA_OFS_CTRL) begin
      next_st.enable = pwdata_i[`JSBA_CTRL_EN_POS];
    end
  end

  // ----------------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------------
  // Reset parks the port in test-logic-reset with bypass selected
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st         <= '0;
      st.tap     <= JSBA_RESET;
      st.ir      <= `JSBA_IR_BYPASS;
      st.enable  <= `JSBA_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign tdo_o         = st.tdo;
  assign tdo_oe_o      = st.tdo_oe;
  assign bus_req_o     = st.bus.req;
  assign bus_msu_o     = st.bus.msu;
  assign bus_write_o   = st.bus.write;
  assign bus_addr_o    = st.bus.addr;
  assign bus_size_o    = st.bus.size;
  assign bus_byte_en_o = st.bus.byte_en;
  assign bus_wdata_o   = st.bus.wdata;
  assign prdata_o      = st.prdata;
  // Zero wait states: every access phase completes at once
  assign pready_o      = 1'b1;
  assign pslverr_o     = st.pslverr;

endmodule
`default_nettype wire

// File: jsba_top_asserts.sv
/*
 * Checker on the service bus and scan pins of the bus access block.
 * Assumes binding onto jsba_top from the bench; all on clock_i.
 */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Bus request shape and handshake, and scan output enable timing
// ----------------------------------------------------------------------
module jsba_top_asserts (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        tck_i,
  input wire logic        tdo_oe_o,
  input wire logic        bus_req_o,
  input wire logic        bus_msu_o,
  input wire logic        bus_write_o,
  input wire logic [35:0] bus_addr_o,
  input wire logic [1:0]  bus_size_o,
  input wire logic [3:0]  bus_byte_en_o,
  input wire logic        bus_ack_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_BYTE_LANE: assert property (bus_req_o && !bus_msu_o && bus_size_o == 2'h0
    |-> bus_byte_en_o == (4'h8 >> bus_addr_o[1:0])) else $error("byte lane wrong");
  AST_HALF_LANE: assert property (bus_req_o && !bus_msu_o && bus_size_o == 2'h1
    |-> !bus_addr_o[0] && bus_byte_en_o == (bus_addr_o[1] ? 4'h3 : 4'hC))
    else $error("halfword lane wrong");
  AST_WORD_ALIGN: assert property (bus_req_o && !bus_msu_o && bus_size_o == 2'h2
    |-> bus_addr_o[1:0] == 2'h0 && bus_byte_en_o == 4'hF) else $error("word shape wrong");
  AST_NO_RSVD: assert property (bus_req_o && !bus_msu_o |-> bus_size_o != 2'h3)
    else $error("reserved size issued");
  AST_MSU_IDX: assert property (bus_req_o && bus_msu_o |-> bus_addr_o[35:7] == 29'h0)
    else $error("index wider than seven bits");
  AST_REQ_HOLD: assert property (bus_req_o && !bus_ack_i |=> bus_req_o &&
    $stable(bus_addr_o) && $stable(bus_write_o)) else $error("request not held");
  AST_REQ_END: assert property (bus_req_o && bus_ack_i |=> !bus_req_o [*2])
    else $error("request outlives its ack");
  AST_OE_FALL: assert property ($rose(tdo_oe_o) |-> !tck_i)
    else $error("output enable moved off a falling tck");
endmodule
`default_nettype wire

// File: jsba_top_tb.sv
/*
 * Bench: scan tasks on the test pins, APB tasks, service bus target.
 * Assumes jsba_target and jsba_top_asserts are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------
module jsba_top_tb;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        tck_i = 1'b0;
  logic        tms_i = 1'b1;
  logic        tdi_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        slow = 1'b0;
  logic        chain = 1'b0;
  logic        tdo_o, tdo_oe_o, bus_req_o, bus_msu_o, bus_write_o, bus_ack_i, bus_err_i;
  logic        pready_o, pslverr_o, e;
  logic [35:0] bus_addr_o;
  logic [1:0]  bus_size_o;
  logic [3:0]  bus_byte_en_o;
  logic [31:0] bus_wdata_o, bus_rdata_i, prdata_o, r;
  logic [38:0] q;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          xfers, x0;
  jsba_top jsba_top_inst (.clock_i, .srst_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o,
    .bus_req_o, .bus_msu_o, .bus_write_o, .bus_addr_o, .bus_size_o, .bus_byte_en_o,
    .bus_wdata_o, .bus_ack_i, .bus_err_i, .bus_rdata_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
  jsba_target jsba_target_inst (.clock_i, .srst_i, .slow_i(slow), .req_i(bus_req_o),
    .write_i(bus_write_o), .addr_i(bus_addr_o), .size_i(bus_size_o), .be_i(bus_byte_en_o),
    .wdata_i(bus_wdata_o), .ack_o(bus_ack_i), .err_o(bus_err_i), .rdata_o(bus_rdata_i),
    .xfers_o(xfers));
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [38:0] ex, input logic [38:0] got);
    tests_run++;
    if (got !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One tck period of 31 clocks; tdo read just before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    @(posedge clock_i);
    tms_i <= ms;
    tdi_i <= di;
    repeat (7) @(posedge clock_i);
    // A released pin reads back inverted, so a late enable shows as bad bits
    dout = tdo_oe_o ? tdo_o : ~tdo_o;
    tck_i <= 1'b1;
    repeat (15) @(posedge clock_i);
    tck_i <= 1'b0;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic scan(input logic [38:0] din, input int n, output logic [38:0] dout,
                      input logic ir);
    logic b;
    dout = '0;
    if (!chain) step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    // An address scan goes straight back to data-register select
    chain = !ir && !chain;
    step(chain, 1'b0, b);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  initial begin
    logic [38:0] bad [5];
    bad = '{{36'h40, 2'h3, 1'b1}, {36'h41, 2'h1, 1'b1}, {36'h42, 2'h2, 1'b1},
            {36'h100, 2'h0, 1'b1}, {36'h40, 2'h2, 1'b1}};
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    step(1'b0, 1'b0, e);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h1F0, r);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h1, r);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 1'b1, e);
    scan(5'h14, 5, q, 1'b1);
    chk("ir capture", 2'b01, q[1:0]);
    scan({31'h0, 7'h2A, 1'b0}, 34, q, 1'b0);
    scan(39'hCAFE0001, 34, q, 1'b0);
    scan({31'h0, 7'h2A, 1'b1}, 34, q, 1'b0);
    scan('0, 34, q, 1'b0);
    chk("msu read", 34'h0CAFE0001, q[33:0]);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h140, r);
    scan(5'h15, 5, q, 1'b1);
    for (int m = 0; m < 4; m++) begin
      scan({36'h40 + m, 2'h0, 1'b0}, 39, q, 1'b0);
      scan(39'(32'h11 * (m + 1) << (8 * (3 - m))), 39, q, 1'b0);
    end
    scan({36'h42, 2'h1, 1'b0}, 39, q, 1'b0);
    scan(39'h0000BEEF, 39, q, 1'b0);
    scan({36'h40, 2'h2, 1'b1}, 39, q, 1'b0);
    scan('0, 8, q, 1'b0);
    chk("early stop", 8'hEF, q[7:0]);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h150, r);
    scan(5'h11, 5, q, 1'b1);
    scan({4'h0, 34'h10, 1'b1}, 35, q, 1'b0);
    chk("word addr status", 2'b00, q[1:0]);
    scan('0, 35, q, 1'b0);
    chk("word read", 35'h01122BEEF, q[34:0]);
    scan({4'h0, 34'h11, 1'b0}, 35, q, 1'b0);
    scan(39'h600DF00D, 35, q, 1'b0);
    scan({4'h0, 34'h11, 1'b1}, 35, q, 1'b0);
    scan('0, 35, q, 1'b0);
    chk("word write", 35'h0600DF00D, q[34:0]);
    scan(5'h15, 5, q, 1'b1);
    for (int k = 0; k < 5; k++) begin
      if (k == 4) apb(1'b1, 12'h000, 32'h0);
      x0 = xfers;
      scan(bad[k], 39, q, 1'b0);
      scan('0, 39, q, 1'b0);
      chk("refused status", 2'b10, q[33:32]);
      chk("transfers", 39'(x0 + (k == 3)), 39'(xfers));
    end
    apb(1'b1, 12'h000, 32'h1);
    slow <= 1'b1;
    scan({36'h40, 2'h2, 1'b1}, 39, q, 1'b0);
    scan('0, 2, q, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk("busy status", 32'h15B, r);
    while (r[1] !== 1'b0) apb(1'b0, 12'h004, 32'h0);
    scan('0, 39, q, 1'b0);
    chk("late read", 39'h01122BEEF, q);
    report_and_stop();
  end
endmodule
bind jsba_top jsba_top_asserts jsba_top_asserts_inst (.clock_i, .srst_i, .tck_i, .tdo_oe_o,
  .bus_req_o, .bus_msu_o, .bus_write_o, .bus_addr_o, .bus_size_o, .bus_byte_en_o, .bus_ack_i);
`default_nettype wire
